/* tdmcfg_top.sv */
// TDM serial port configuration register, slot routing and frame control
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tdmcfg_top
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic power_down_pin_n,
  input wire logic link_clk,
  input wire logic master_mode,
  input wire logic link_rx,
  output logic link_tx,
  output logic link_fsync,
  output logic bit_clock_rate_sel,
  input wire tdmcfg_pkg::tdmcfg_cap_t cap,
  output tdmcfg_pkg::tdmcfg_play_t play,
  output logic play_valid
);

  // ----------------------------------------------------------------
  // State of both domains
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [1:0] rst_pin_sync;
    logic [1:0] pd_pin_sync;
    tdmcfg_pkg::tdmcfg_cfg_t cfg;
    tdmcfg_pkg::tdmcfg_cfg_t xfer_cfg;
    logic xfer_req;
    logic [1:0] ack_sync;
    logic [31:0] prdata;
    logic pslverr;
  } tdmcfg_bus_state_t;

  typedef struct packed
  {
    logic [1:0] rst_sync;
    logic [1:0] master_sync;
    logic [2:0] req_sync;
    tdmcfg_pkg::tdmcfg_cfg_t cfg;
    logic clk_sel_pend;
    logic clk_sel_act;
    logic frame16_pend;
    logic frame16_act;
    logic [3:0] bit_cnt;
    logic [4:0] slot_cnt;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [3:0][15:0] words;
    logic [15:0] right_hold;
    logic cap_l_pend;
    logic cap_r_pend;
    logic [15:0] cap_l_smp;
    logic [15:0] cap_r_smp;
    tdmcfg_pkg::tdmcfg_play_t play;
    logic play_valid;
    logic play_load;
    logic fsync;
  } tdmcfg_link_state_t;

  tdmcfg_bus_state_t b_reg;
  tdmcfg_bus_state_t b_next;
  tdmcfg_link_state_t l_reg;
  tdmcfg_link_state_t l_next;
  logic [15:0] lin [tdmcfg_pkg::PLAY_SLOTS];
  localparam int unsigned CAP_CHANS = 2;
  logic [15:0] enc [CAP_CHANS];

  // ----------------------------------------------------------------
  // Format converters
  // ----------------------------------------------------------------
  // Playback decoders, one per received slot; their encode half is unused
  generate
    for (genvar i = 0; i < tdmcfg_pkg::PLAY_SLOTS; i++)
    begin : g_conv
      tdmcfg_compander u_conv
      (
        .fmt((i < 2) ? l_reg.cfg.play_pair_a_format : l_reg.cfg.play_pair_b_format),
        .slot_in(l_reg.words[i]),
        .lin_out(lin[i]),
        .lin_in(16'h0000),
        .slot_out()
      );
    end
  endgenerate

  // Capture encoders of their own: sharing a playback decoder would use its format
  generate
    for (genvar i = 0; i < CAP_CHANS; i++)
    begin : g_enc
      tdmcfg_compander u_enc
      (
        .fmt((i == 0) ? l_reg.cfg.capture_left_format : l_reg.cfg.capture_right_format),
        .slot_in(16'h0000),
        .lin_out(),
        .lin_in((i == 0) ? l_reg.cap_l_smp : l_reg.cap_r_smp),
        .slot_out(enc[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register bus side
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready = psel & penable;
  assign prdata = b_reg.prdata;
  assign pslverr = b_reg.pslverr;

  // Pin sync, register writes and the handshake toward the link domain
  always_comb
  begin
    logic hold;
    logic pending;
    logic hit_cfg;
    logic hit_stat;
    logic [15:0] wr_val;
    hold = 1'b0;
    pending = 1'b0;
    hit_cfg = 1'b0;
    hit_stat = 1'b0;
    wr_val = 16'h0000;
    b_next = b_reg;
    b_next.rst_pin_sync = {b_reg.rst_pin_sync[0], reset_pin_n};
    b_next.pd_pin_sync = {b_reg.pd_pin_sync[0], power_down_pin_n};
    b_next.ack_sync = {b_reg.ack_sync[0], l_reg.req_sync[2]};
    hold = ~b_reg.rst_pin_sync[1] | ~b_reg.pd_pin_sync[1];
    pending = b_reg.xfer_req ^ b_reg.ack_sync[1];
    hit_cfg = (paddr == tdmcfg_pkg::ADDR_CFG);
    hit_stat = (paddr == tdmcfg_pkg::ADDR_STATUS);
    // Byte lanes 0 and 1 only; reserved positions always stay zero
    wr_val = b_reg.cfg;
    if (pstrb[0])
      wr_val[7:0] = pwdata[7:0];
    if (pstrb[1])
      wr_val[15:8] = pwdata[15:8];
    if (hold)
      b_next.cfg = tdmcfg_pkg::CFG_RESET;
    else if (psel && penable && pwrite && hit_cfg)
      b_next.cfg = tdmcfg_pkg::tdmcfg_cfg_t'(wr_val & tdmcfg_pkg::CFG_WRITE_MASK);
    // Read data captured in setup so it stands through the access cycle
    if (psel && !penable)
    begin
      b_next.pslverr = ~(hit_cfg | hit_stat);
      b_next.prdata = 32'h0000_0000;
      if (!pwrite && hit_cfg)
        b_next.prdata[15:0] = b_reg.cfg;
      if (!pwrite && hit_stat)
      begin
        b_next.prdata[tdmcfg_pkg::STAT_PENDING_BIT] = pending;
        b_next.prdata[tdmcfg_pkg::STAT_HOLD_BIT] = hold;
      end
    end
    // Snapshot held steady until the link domain acknowledges it
    if (!pending && (b_reg.cfg != b_reg.xfer_cfg))
    begin
      b_next.xfer_cfg = b_reg.cfg;
      b_next.xfer_req = ~b_reg.xfer_req;
    end
  end

  // Bus-domain register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      b_reg <= '0;
    else
      b_reg <= b_next;
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  assign link_tx = l_reg.tx_shift[15];
  assign link_fsync = l_reg.fsync;
  assign bit_clock_rate_sel = l_reg.clk_sel_act & l_reg.master_sync[1];
  assign play = l_reg.play;
  assign play_valid = l_reg.play_valid;

  // Framing, slot routing, capture pairing and config take-over
  always_comb
  begin
    logic slot_end;
    logic wrap;
    logic send_l;
    logic send_r;
    logic [4:0] frame_last;
    logic [4:0] idx;
    logic [15:0] word;
    slot_end = 1'b0;
    wrap = 1'b0;
    send_l = 1'b0;
    send_r = 1'b0;
    frame_last = tdmcfg_pkg::FRAME_LAST_32;
    idx = 5'h00;
    word = 16'h0000;
    l_next = l_reg;
    l_next.play_valid = 1'b0;
    l_next.play_load = 1'b0;
    l_next.fsync = 1'b0;
    // Captured config arrives only after the snapshot has settled
    if (l_reg.req_sync[1] ^ l_reg.req_sync[2])
    begin
      l_next.cfg = b_reg.xfer_cfg;
      l_next.clk_sel_pend = b_reg.xfer_cfg.bit_clock_freq_select;
      l_next.frame16_pend = b_reg.xfer_cfg.frame_slot_count_select;
    end
    slot_end = (l_reg.bit_cnt == tdmcfg_pkg::BIT_LAST);
    frame_last = l_reg.frame16_act ? tdmcfg_pkg::FRAME_LAST_16 : tdmcfg_pkg::FRAME_LAST_32;
    // At-or-above catches a shrink to 16 slots made late in a 32-slot frame
    wrap = slot_end && (l_reg.slot_cnt >= frame_last);
    l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
    l_next.rx_shift = {l_reg.rx_shift[14:0], link_rx};
    l_next.tx_shift = {l_reg.tx_shift[14:0], 1'b0};
    if (slot_end)
    begin
      word = {l_reg.rx_shift[14:0], link_rx};
      idx = l_reg.slot_cnt - tdmcfg_pkg::SLOT_PAIR_A_LEFT;
      if (l_reg.slot_cnt >= tdmcfg_pkg::SLOT_PAIR_A_LEFT && l_reg.slot_cnt <= tdmcfg_pkg::SLOT_PAIR_B_RIGHT)
        l_next.words[idx[1:0]] = word;
      if (l_reg.slot_cnt == tdmcfg_pkg::SLOT_LAST_OWNED)
      begin
        l_next.clk_sel_act = l_reg.clk_sel_pend;
        l_next.play_load = 1'b1;
      end
      l_next.slot_cnt = wrap ? 5'h00 : (l_reg.slot_cnt + 5'h01);
      l_next.tx_shift = 16'h0000;
      if (l_reg.slot_cnt == tdmcfg_pkg::SLOT_CAP_LEFT)
        l_next.tx_shift = l_reg.right_hold;
    end
    // Deferred size change lands at the frame boundary
    if (wrap)
    begin
      l_next.frame16_act = l_reg.frame16_pend;
      l_next.fsync = 1'b1;
      if (l_reg.cfg.capture_transmit_lock)
      begin
        send_l = l_reg.cap_l_pend & l_reg.cap_r_pend;
        send_r = send_l;
      end
      else
      begin
        send_l = l_reg.cap_l_pend;
        send_r = l_reg.cap_r_pend;
      end
      // Empty capture slots go out as zero
      l_next.tx_shift = send_l ? enc[0] : 16'h0000;
      l_next.right_hold = send_r ? enc[1] : 16'h0000;
      if (send_l)
        l_next.cap_l_pend = 1'b0;
      if (send_r)
        l_next.cap_r_pend = 1'b0;
    end
    // Immediate mode overrides the boundary value, also for this frame
    if ((l_reg.req_sync[1] ^ l_reg.req_sync[2]) && b_reg.xfer_cfg.frame_size_change_timing)
      l_next.frame16_act = b_reg.xfer_cfg.frame_slot_count_select;
    // A new sample in the sending cycle wins over the clear
    if (cap.left_valid)
    begin
      l_next.cap_l_pend = 1'b1;
      l_next.cap_l_smp = cap.left;
    end
    if (cap.right_valid)
    begin
      l_next.cap_r_pend = 1'b1;
      l_next.cap_r_smp = cap.right;
    end
    // Playback words decoded one cycle after slot 5 is in
    if (l_reg.play_load)
    begin
      l_next.play_valid = 1'b1;
      l_next.play.a_left = lin[0];
      l_next.play.a_right = l_reg.cfg.play_pair_a_mono_select ? lin[0] : lin[1];
      l_next.play.b_left = lin[2];
      l_next.play.b_right = l_reg.cfg.play_pair_b_mono_select ? lin[2] : lin[3];
    end
    // Reset clears the link state; synchronisers keep running
    if (l_reg.rst_sync[1])
    begin
      l_next = '0;
      l_next.req_sync = l_reg.req_sync;
    end
    l_next.rst_sync = {l_reg.rst_sync[0], sys_rst};
    l_next.master_sync = {l_reg.master_sync[0], master_mode};
    l_next.req_sync = {l_reg.req_sync[1:0], b_reg.xfer_req};
  end

  // Link-domain register; reset arrives through its own synchroniser
  always_ff @(posedge link_clk)
  begin
    l_reg <= l_next;
  end

endmodule
`default_nettype wire

/* tdmcfg_pkg.sv */
// Shared constants and types of the TDM serial port configuration block
package tdmcfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Reserved positions 13:12 never store a one
  localparam logic [15:0] CFG_WRITE_MASK = 16'hcfff;
  localparam int unsigned STAT_PENDING_BIT = 0;
  localparam int unsigned STAT_HOLD_BIT = 1;

  // ----------------------------------------------------------------
  // Slot data formats and register layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    FMT_U8 = 2'b00,
    FMT_S16 = 2'b01,
    FMT_ULAW = 2'b10,
    FMT_ALAW = 2'b11
  } tdmcfg_fmt_t;

  typedef struct packed
  {
    logic play_pair_b_mono_select;
    logic play_pair_a_mono_select;
    logic [1:0] reserved;
    tdmcfg_fmt_t play_pair_b_format;
    tdmcfg_fmt_t play_pair_a_format;
    logic bit_clock_freq_select;
    logic frame_slot_count_select;
    logic frame_size_change_timing;
    logic capture_transmit_lock;
    tdmcfg_fmt_t capture_right_format;
    tdmcfg_fmt_t capture_left_format;
  } tdmcfg_cfg_t;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned SLOT_W = 16;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [4:0] SLOT_CAP_LEFT = 5'h00;
  localparam logic [4:0] SLOT_PAIR_A_LEFT = 5'h02;
  localparam logic [4:0] SLOT_PAIR_B_RIGHT = 5'h05;
  localparam logic [4:0] SLOT_LAST_OWNED = 5'h05;
  localparam logic [4:0] FRAME_LAST_32 = 5'h1f;
  localparam logic [4:0] FRAME_LAST_16 = 5'h0f;
  localparam int unsigned PLAY_SLOTS = 4;

  // ----------------------------------------------------------------
  // Link-side bundles
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic left_valid;
    logic [15:0] left;
    logic right_valid;
    logic [15:0] right;
  } tdmcfg_cap_t;

  typedef struct packed
  {
    logic [15:0] a_left;
    logic [15:0] a_right;
    logic [15:0] b_left;
    logic [15:0] b_right;
  } tdmcfg_play_t;

endpackage

/* tdmcfg_compander.sv */
// Slot word to linear sample conversion and back, per format
`timescale 1ns/100ps
`default_nettype none
module tdmcfg_compander
(
  input wire tdmcfg_pkg::tdmcfg_fmt_t fmt,
  input wire logic [15:0] slot_in,
  output logic [15:0] lin_out,
  input wire logic [15:0] lin_in,
  output logic [15:0] slot_out
);

  // ----------------------------------------------------------------
  // Companding constants
  // ----------------------------------------------------------------
  localparam logic [15:0] ULAW_BIAS = 16'h0084;
  localparam logic [15:0] ULAW_CLIP = 16'h7f7b;
  localparam logic [3:0] ULAW_SHIFT = 4'h3;
  localparam logic [7:0] ALAW_XOR = 8'h55;
  localparam logic [7:0] ALAW_POS = 8'hd5;
  localparam logic [15:0] ALAW_ROUND = 16'h0008;
  localparam logic [15:0] ALAW_SEG_BIAS = 16'h0108;
  localparam logic [7:0] SIGN_FLIP = 8'h80;
  localparam logic [7:0] PAD = 8'h00;

  // Mu-law byte to 16-bit linear
  function automatic logic [15:0] ulaw_expand(input logic [7:0] code);
    logic [7:0] u;
    logic [15:0] t;
    u = ~code;
    t = 16'({u[3:0], 3'b000}) + ULAW_BIAS;
    t = t << u[6:4];
    return u[7] ? (ULAW_BIAS - t) : (t - ULAW_BIAS);
  endfunction

  // A-law byte to 16-bit linear
  function automatic logic [15:0] alaw_expand(input logic [7:0] code);
    logic [7:0] a;
    logic [15:0] t;
    a = code ^ ALAW_XOR;
    t = 16'({a[3:0], 4'h0});
    if (a[6:4] == 3'h0)
      t = t + ALAW_ROUND;
    else
      t = (t + ALAW_SEG_BIAS) << (a[6:4] - 3'h1);
    return a[7] ? t : (16'h0000 - t);
  endfunction

  // 16-bit linear to mu-law byte; magnitude clipped before biasing
  function automatic logic [7:0] ulaw_compress(input logic [15:0] lin);
    logic neg;
    logic [15:0] mag;
    logic [2:0] ex;
    logic [15:0] sh;
    neg = lin[15];
    mag = neg ? (16'h0000 - lin) : lin;
    if (mag > ULAW_CLIP)
      mag = ULAW_CLIP;
    mag = mag + ULAW_BIAS;
    ex = 3'h0;
    for (int i = 0; i < 8; i++)
      if (mag[i + 7])
        ex = 3'(i);
    sh = mag >> ({1'b0, ex} + ULAW_SHIFT);
    return ~{neg, ex, sh[3:0]};
  endfunction

  // 16-bit linear to A-law byte; one's complement keeps -32768 in range
  function automatic logic [7:0] alaw_compress(input logic [15:0] lin);
    logic neg;
    logic [15:0] mag;
    logic [11:0] m;
    logic [2:0] seg;
    logic [11:0] sh;
    neg = lin[15];
    mag = neg ? ~lin : lin;
    m = mag[14:3];
    seg = 3'h0;
    for (int i = 1; i < 8; i++)
      if (m[i + 4])
        seg = 3'(i);
    sh = (seg == 3'h0) ? (m >> 1) : (m >> seg);
    return {1'b0, seg, sh[3:0]} ^ (neg ? ALAW_XOR : ALAW_POS);
  endfunction

  // Both directions; 8-bit codes travel in the upper byte of the slot
  always_comb
  begin
    case (fmt)
      tdmcfg_pkg::FMT_U8:
      begin
        lin_out = {slot_in[15:8] ^ SIGN_FLIP, PAD};
        slot_out = {lin_in[15:8] ^ SIGN_FLIP, PAD};
      end
      tdmcfg_pkg::FMT_ULAW:
      begin
        lin_out = ulaw_expand(slot_in[15:8]);
        slot_out = {ulaw_compress(lin_in), PAD};
      end
      tdmcfg_pkg::FMT_ALAW:
      begin
        lin_out = alaw_expand(slot_in[15:8]);
        slot_out = {alaw_compress(lin_in), PAD};
      end
      default:
      begin
        lin_out = slot_in;
        slot_out = lin_in;
      end
    endcase
  end

endmodule
`default_nettype wire

/* tdmcfg_sva.sv */
// Checker of bus answers and link framing of the TDM configuration block
`timescale 1ns/100ps
`default_nettype none
module tdmcfg_sva
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic link_clk,
  input wire logic master_mode,
  input wire logic link_fsync,
  input wire logic bit_clock_rate_sel,
  input wire tdmcfg_pkg::tdmcfg_play_t play,
  input wire logic play_valid
);
  logic [9:0] cnt_reg;
  logic seen_reg;
  // ----
  // Link cycles since the last sync pulse
  // ----
  // Only trusted after one sync, the first frame has none
  always_ff @(posedge link_clk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 10'h000;
      seen_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= link_fsync ? 10'h001 : cnt_reg + 10'h001;
      seen_reg <= seen_reg | link_fsync;
    end
  end
  // ----
  // Bus side
  // ----
  a_reset_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> prdata == 32'h0000_0000 && !pslverr) else $error("bus outputs not clear after reset");
  a_read_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    psel && penable && !pwrite && pready |-> prdata[31:16] == 16'h0000 && prdata[13:12] == 2'b00)
    else $error("reserved read bits not zero");
  // ----
  // Link side
  // ----
  a_rate_slave: assert property (@(posedge link_clk) disable iff (sys_rst)
    (!master_mode)[*5] |-> !bit_clock_rate_sel) else $error("rate select active in slave mode");
  a_fsync_single: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_fsync |=> (!link_fsync)[*8]) else $error("sync pulse too long");
  a_frame_len: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_fsync && seen_reg |-> cnt_reg[3:0] == 4'h0 && cnt_reg <= 10'h200) else $error("frame not whole slots");
  a_play_hold: assert property (@(posedge link_clk) disable iff (sys_rst)
    $changed(play) |-> play_valid) else $error("play changed without valid");
  a_valid_pulse: assert property (@(posedge link_clk) disable iff (sys_rst)
    play_valid |=> !play_valid) else $error("play valid longer than one cycle");
  a_play_slot: assert property (@(posedge link_clk) disable iff (sys_rst)
    play_valid && seen_reg |-> cnt_reg inside {[95:99]}) else $error("play update off slot five end");
endmodule
bind tdmcfg_top tdmcfg_sva tdmcfg_sva_inst (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .link_clk(link_clk), .master_mode(master_mode), .link_fsync(link_fsync),
  .bit_clock_rate_sel(bit_clock_rate_sel), .play(play), .play_valid(play_valid));
`default_nettype wire

/* tdmcfg_dsp_model.sv */
// Serial port model of the signal processor across the TDM link
`timescale 1ns/100ps
`default_nettype none
module tdmcfg_dsp_model
(
  input wire logic link_clk,
  input wire logic link_fsync,
  input wire logic link_tx,
  input wire logic [63:0] rx_words,
  output logic link_rx,
  output logic [31:0] tx_words
);
  logic [8:0] pos_reg = 9'h000;
  int cur;
  int nxt;
  initial link_rx = 1'b0;
  initial tx_words = 32'h0000_0000;
  // ----
  // Frame position and serial data
  // ----
  // Sync marks position zero; slots are sixteen bits, MSB first
  always @(posedge link_clk)
  begin
    cur = link_fsync ? 0 : int'(pos_reg);
    nxt = cur + 1;
    pos_reg <= 9'(nxt);
    if (cur < 32)
      tx_words[31 - cur] <= link_tx;
    // Words for slots 2 to 5; idle slots toggle so stale bits never pass
    if (nxt >= 32 && nxt < 96)
      link_rx <= rx_words[95 - nxt];
    else
      link_rx <= ~link_rx;
  end
endmodule
`default_nettype wire

/* tdmcfg_top_tb.sv */
// Self-checking bench of the TDM serial port configuration block
`timescale 1ns/100ps
`default_nettype none
module tdmcfg_top_tb;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, link_rx, link_tx, link_fsync, bit_clock_rate_sel, play_valid, er;
  logic [31:0] prdata, rd, tx_words;
  logic reset_pin_n = 1'b1;
  logic power_down_pin_n = 1'b1;
  logic master_mode = 1'b0;
  logic [31:0] seed = 32'h5246_70d4;
  logic [63:0] rx_words = 64'h0;
  logic [15:0] cl, cr;
  logic [1:0] fa, fb;
  tdmcfg_pkg::tdmcfg_cap_t cap = '0;
  tdmcfg_pkg::tdmcfg_play_t play, ex;
  int error_cnt = 0;
  int checks = 0;
  int len;
  // ----
  // Clocks, design and far side
  // ----
  initial forever #2.5 clk = ~clk;
  initial
  begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  tdmcfg_top tdmcfg_top_inst (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .power_down_pin_n(power_down_pin_n), .link_clk(link_clk),
    .master_mode(master_mode), .link_rx(link_rx), .link_tx(link_tx), .link_fsync(link_fsync),
    .bit_clock_rate_sel(bit_clock_rate_sel), .cap(cap), .play(play), .play_valid(play_valid));
  tdmcfg_dsp_model tdmcfg_dsp_model_inst (.link_clk(link_clk), .link_fsync(link_fsync), .link_tx(link_tx),
    .rx_words(rx_words), .link_rx(link_rx), .tx_words(tx_words));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Linear value of a slot word; only mu-law ff (silence) and A-law d5 (+8) are checked
  function automatic logic [15:0] lin(input logic [1:0] f, input logic [15:0] w);
    case (f)
      2'b00: return {~w[15], w[14:8], 8'h00};
      2'b01: return w;
      2'b10: return 16'h0000;
      default: return 16'h0008;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait on a slave that never answers
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write the config and wait until it has crossed to the link side
  task automatic setcfg(input logic [31:0] d);
    int n;
    n = 0;
    apb(1'b1, tdmcfg_pkg::ADDR_CFG, d);
    do
    begin
      apb(1'b0, tdmcfg_pkg::ADDR_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 100);
    if (rd[0] !== 1'b0)
      error_cnt++;
  endtask
  task automatic wait_pv();
    int n;
    n = 0;
    do
    begin
      @(posedge link_clk);
      #1;
      n++;
    end
    while (play_valid !== 1'b1 && n < 1200);
    if (n >= 1200)
      error_cnt++;
  endtask
  task automatic cappulse(input logic l, input logic r);
    @(posedge link_clk);
    cap <= '{l, cl, r, cr};
    @(posedge link_clk);
    cap <= '0;
  endtask
  // Edges from one sync to the next; always steps an edge before looking
  task automatic meas(output int l);
    int n;
    n = 0;
    do
    begin
      @(posedge link_clk);
      n++;
    end
    while (link_fsync !== 1'b1 && n < 2000);
    l = 0;
    do
    begin
      @(posedge link_clk);
      l++;
    end
    while (link_fsync !== 1'b1 && l < 2000);
  endtask
  // Hang guard sized for about fifteen long frames or thirty short ones
  initial
  begin
    #490_000;
    error_cnt++;
    finish_test();
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, tdmcfg_pkg::ADDR_CFG, 32'h0);
    chk("cfg reset", rd, 32'h0000_0000);
    apb(1'b1, tdmcfg_pkg::ADDR_CFG, 32'hffff_ffff);
    apb(1'b0, tdmcfg_pkg::ADDR_CFG, 32'h0);
    chk("cfg mask", rd, 32'h0000_cfff);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", er, 1'b1);
    $display("Test register done");
    // Routing: every mono pairing and every slot format
    for (int i = 0; i < 4; i++)
    begin
      fa = (i == 2) ? 2'b00 : (i == 3) ? 2'b10 : 2'b01;
      fb = (i == 1) ? 2'b00 : (i == 3) ? 2'b11 : 2'b01;
      rx_words = {rnd(), rnd()};
      if (i == 3)
        rx_words = {16'hff00, rx_words[47:32], 16'hd500, rx_words[15:0]};
      setcfg({16'h0, i[1], i[0], 2'b00, fb, fa, 8'h45});
      ex.a_left = lin(fa, rx_words[63:48]);
      ex.a_right = lin(fa, i[0] ? rx_words[63:48] : rx_words[47:32]);
      ex.b_left = lin(fb, rx_words[31:16]);
      ex.b_right = lin(fb, i[1] ? rx_words[31:16] : rx_words[15:0]);
      wait_pv();
      wait_pv();
      chk("a left", play.a_left, ex.a_left);
      chk("a right", play.a_right, ex.a_right);
      chk("b left", play.b_left, ex.b_left);
      chk("b right", play.b_right, ex.b_right);
    end
    $display("Test routing done");
    // Capture sends, unlocked then locked
    {cl, cr} = rnd();
    wait_pv();
    cappulse(1'b1, 1'b0);
    wait_pv();
    chk("tx unlocked", tx_words, {cl, 16'h0000});
    setcfg(32'h0000_0055);
    wait_pv();
    cappulse(1'b1, 1'b0);
    wait_pv();
    chk("tx lock held", tx_words, 32'h0000_0000);
    cappulse(1'b0, 1'b1);
    wait_pv();
    chk("tx lock pair", tx_words, {cl, cr});
    $display("Test capture done");
    // Bit clock rate select in master and slave mode
    @(posedge clk);
    master_mode <= 1'b1;
    setcfg(32'h0000_00c5);
    wait_pv();
    wait_pv();
    chk("rate master", bit_clock_rate_sel, 1'b1);
    @(posedge clk);
    master_mode <= 1'b0;
    wait_pv();
    chk("rate slave", bit_clock_rate_sel, 1'b0);
    $display("Test rate done");
    // Frame length for both sizes and both timings
    for (int i = 0; i < 3; i++)
    begin
      setcfg({24'h0, 1'b0, i[0], i[1], 5'h05});
      meas(len);
      chk("frame length", len, i[0] ? 256 : 512);
    end
    $display("Test frame done");
    // Pin hold clears the register and refuses writes
    for (int i = 0; i < 2; i++)
    begin
      setcfg(32'h0000_8001);
      if (i == 0)
        reset_pin_n <= 1'b0;
      else
        power_down_pin_n <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b1, tdmcfg_pkg::ADDR_CFG, 32'h0000_4002);
      apb(1'b0, tdmcfg_pkg::ADDR_CFG, 32'h0);
      chk("cfg held", rd, 32'h0000_0000);
      apb(1'b0, tdmcfg_pkg::ADDR_STATUS, 32'h0);
      chk("hold flag", rd[1], 1'b1);
      reset_pin_n <= 1'b1;
      power_down_pin_n <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b0, tdmcfg_pkg::ADDR_CFG, 32'h0);
      chk("cfg cleared", rd, 32'h0000_0000);
    end
    $display("Test pins done");
    finish_test();
  end
endmodule
`default_nettype wire
